/* logic/lp_attach_map.svh */
// Constants for the line printer attachment: opcodes, device address, condition and register codes.
// Assumes it is included by bare name from the package and the attachment module.
`ifndef LP_ATTACH_MAP_SVH
`define LP_ATTACH_MAP_SVH

// ========================================
// Device address in the qualifier byte
`define LPA_DEV_ADDR 4'he

// ========================================
// Opcodes answered by the attachment
`define LPA_OP_TEST_DIRECT 8'hc1
`define LPA_OP_TEST_XR1 8'hd1
`define LPA_OP_TEST_XR2 8'he1
`define LPA_OP_ADVANCE 8'hf1
`define LPA_OP_LOAD_DIRECT 8'h31
`define LPA_OP_LOAD_XR1 8'h71
`define LPA_OP_LOAD_XR2 8'hb1
`define LPA_OP_SENSE_DIRECT 8'h30
`define LPA_OP_SENSE_XR1 8'h70
`define LPA_OP_SENSE_XR2 8'hb0

// ========================================
// Condition-select codes with the modifier bit at 0
`define LPA_COND_NOT_READY 3'h1
`define LPA_COND_BUF_BUSY 3'h2
`define LPA_COND_IRQ_PENDING 3'h3
`define LPA_COND_CARR_BUSY 3'h4
`define LPA_COND_PRINTER_BUSY 3'h5
// Condition-select code that tests diagnostic mode off with the modifier bit at 1
`define LPA_COND_DIAG_OFF 3'h1

// ========================================
// Register-select codes of the load instruction
`define LPA_LOAD_FORMS 3'h0
`define LPA_LOAD_IMAGE 3'h4
`define LPA_LOAD_DATA 3'h6

// ========================================
// Pin input positions in the synchronised vector
`define LPA_PIN_NOT_READY 0
`define LPA_PIN_LINE_DONE 1
`define LPA_PIN_MOTION_DONE_L 2
`define LPA_PIN_MOTION_DONE_R 3
`define LPA_PIN_DIAG_OFF 4
`define LPA_PIN_DUAL_CARRIAGE 5
`define LPA_PIN_VARIANT_DUAL 6
`define LPA_PIN_COUNT 7

`endif

/* logic/lp_attach_pkg.sv */
// Types shared by the line printer attachment.
// Assumes the constants header is on the include path.
`include "lp_attach_map.svh"

package lp_attach_pkg;

    // ========================================
    // Kinds of instruction the attachment decodes.
    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_TEST,
        KIND_ADVANCE,
        KIND_LOAD,
        KIND_SENSE
    } instr_kind_t;

endpackage

/* logic/lp_sync.sv */
// Two-flop synchroniser for a vector of independent level pins.
// Assumes each bit is a slow level; no bit relation is kept across the vector.
module lp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Asynchronous levels and their synchronised copies.
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule

/* logic/lp_attach.sv */
// Line printer attachment: answers test, advance-level, load and sense instructions and posts op-end requests.
// Assumes the processor core presents one instruction pulse at a time on the core clock and decodes start commands.
`include "lp_attach_map.svh"

module lp_attach #(
    parameter int ADDR_W = 16
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Instruction from the processor core.
    input wire logic i_instr_valid,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_qbyte,
    input wire logic i_qbyte_parity,
    input wire logic [ADDR_W-1:0] i_operand_addr,
    input wire logic [ADDR_W-1:0] i_next_addr,
    input wire logic [7:0] i_data_ea,
    input wire logic [7:0] i_data_ea_m1,
    // Processor state.
    input wire logic i_level7_enabled,
    input wire logic i_interrupt_model,
    input wire logic i_dual_installed,
    input wire logic i_dual_enabled,
    input wire logic i_check_reset,
    // Start commands accepted by the core.
    input wire logic i_start_accept,
    input wire logic i_start_print,
    input wire logic i_start_motion,
    input wire logic i_start_right,
    input wire logic i_start_refused,
    input wire logic i_start_int_enable,
    input wire logic i_start_int_disable,
    input wire logic i_start_reset_enable,
    // Printer mechanism pins.
    input wire logic i_mech_not_ready,
    input wire logic i_mech_line_done,
    input wire logic i_mech_motion_done_l,
    input wire logic i_mech_motion_done_r,
    input wire logic i_mech_diag_off,
    input wire logic i_strap_dual_carriage,
    input wire logic i_strap_variant_dual,
    // Instruction answer.
    output logic o_done,
    output logic o_branch,
    output logic o_repeat,
    output logic o_level_advance,
    output logic o_program_check,
    output logic o_processor_check,
    output logic o_invalid_dev_addr,
    output logic [ADDR_W-1:0] o_iar,
    output logic [ADDR_W-1:0] o_arr,
    // Attachment state.
    output logic o_irq_req,
    output logic o_refused,
    output logic o_parity_light,
    output logic o_buf_busy,
    output logic [1:0] o_carr_busy,
    output logic o_printer_busy,
    output logic [7:0] o_forms_left,
    output logic [7:0] o_forms_right,
    output logic [ADDR_W-1:0] o_image_addr,
    output logic [ADDR_W-1:0] o_data_addr
);

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    // ========================================
    // Pin synchronisation and completion edges
    logic [`LPA_PIN_COUNT-1:0] pins;
    logic [2:0] done_prev_reg;
    logic line_rise, ml_rise, mr_rise;

    lp_sync #(.WIDTH(`LPA_PIN_COUNT)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_strap_variant_dual, i_strap_dual_carriage, i_mech_diag_off, i_mech_motion_done_r,
                  i_mech_motion_done_l, i_mech_line_done, i_mech_not_ready}),
        .o_sync(pins)
    );

    // Completion strobes are rising edges of the synchronised done levels.
    assign line_rise = pins[`LPA_PIN_LINE_DONE] & ~done_prev_reg[0];
    assign ml_rise = pins[`LPA_PIN_MOTION_DONE_L] & ~done_prev_reg[1];
    assign mr_rise = pins[`LPA_PIN_MOTION_DONE_R] & ~done_prev_reg[2];

    // ========================================
    // Busy conditions
    logic buf_next, pbusy_next;
    logic [1:0] carr_next;
    logic carr_sel;

    // Right carriage is chosen only when the dual-carriage strap is fitted, whatever the variant strap.
    assign carr_sel = i_start_right & pins[`LPA_PIN_DUAL_CARRIAGE];

    // Set wins over a completion edge arriving in the same cycle.
    always_comb begin
        buf_next = (o_buf_busy & ~line_rise) | (i_start_accept & i_start_print);
        carr_next[0] = (o_carr_busy[0] & ~ml_rise) | (i_start_accept & i_start_motion & ~carr_sel);
        carr_next[1] = (o_carr_busy[1] & ~mr_rise) | (i_start_accept & i_start_motion & carr_sel);
        pbusy_next = i_start_accept | (o_printer_busy & (buf_next | (|carr_next)));
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            done_prev_reg <= 3'h0;
            o_buf_busy <= 1'b0;
            o_carr_busy <= 2'h0;
            o_printer_busy <= 1'b0;
        end else begin
            done_prev_reg <= {pins[`LPA_PIN_MOTION_DONE_R], pins[`LPA_PIN_MOTION_DONE_L], pins[`LPA_PIN_LINE_DONE]};
            o_buf_busy <= buf_next;
            o_carr_busy <= carr_next;
            o_printer_busy <= pbusy_next;
        end
    end

    a_buf_busy_set: assert property (i_start_accept && i_start_print |=> o_buf_busy)
        else $error("Buffer busy did not set on print start.");
    a_printer_busy_hold: assert property (o_printer_busy && (o_buf_busy || (|o_carr_busy)) && !line_rise
        && !ml_rise && !mr_rise |=> o_printer_busy)
        else $error("Printer busy dropped while work remained.");

    // ========================================
    // Instruction decode
    lp_attach_pkg::instr_kind_t kind;
    logic ours, parity_ok, m_bit, sel_invalid, sel_hit, check_is_program;
    logic [2:0] n_code;

    // Selected condition, shared by test and advance-level.
    function automatic logic cond_hit(input logic m, input logic [2:0] n, input logic variant_dual,
                                      input logic carr_busy);
        logic hit;
        hit = 1'b0;
        if (m && !variant_dual) begin
            hit = pins[`LPA_PIN_DIAG_OFF];
        end else begin
            unique case (n)
                `LPA_COND_NOT_READY: hit = pins[`LPA_PIN_NOT_READY];
                `LPA_COND_BUF_BUSY: hit = o_buf_busy;
                `LPA_COND_IRQ_PENDING: hit = o_irq_req;
                `LPA_COND_CARR_BUSY: hit = carr_busy;
                `LPA_COND_PRINTER_BUSY: hit = o_printer_busy;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    // Only qualifiers carrying the printer address are answered.
    assign ours = i_instr_valid && (i_qbyte[7:4] == `LPA_DEV_ADDR);
    assign parity_ok = ^{i_qbyte, i_qbyte_parity};
    assign m_bit = i_qbyte[3];
    assign n_code = i_qbyte[2:0];
    assign check_is_program = i_level7_enabled & i_interrupt_model;

    always_comb begin
        unique case (i_opcode)
            `LPA_OP_TEST_DIRECT, `LPA_OP_TEST_XR1, `LPA_OP_TEST_XR2: kind = lp_attach_pkg::KIND_TEST;
            `LPA_OP_ADVANCE: kind = lp_attach_pkg::KIND_ADVANCE;
            `LPA_OP_LOAD_DIRECT, `LPA_OP_LOAD_XR1, `LPA_OP_LOAD_XR2: kind = lp_attach_pkg::KIND_LOAD;
            `LPA_OP_SENSE_DIRECT, `LPA_OP_SENSE_XR1, `LPA_OP_SENSE_XR2: kind = lp_attach_pkg::KIND_SENSE;
            default: kind = lp_attach_pkg::KIND_NONE;
        endcase
        // Dual variant: modifier picks carriage; other variant: modifier 1 only with diagnostic code.
        sel_invalid = pins[`LPA_PIN_VARIANT_DUAL] ? (m_bit & ~pins[`LPA_PIN_DUAL_CARRIAGE])
                                                : (m_bit & (n_code != `LPA_COND_DIAG_OFF));
        sel_hit = cond_hit(m_bit, n_code, pins[`LPA_PIN_VARIANT_DUAL],
                           pins[`LPA_PIN_VARIANT_DUAL] ? o_carr_busy[m_bit] : o_carr_busy[0]);
    end

    // ========================================
    // Instruction answer and loadable registers
    logic done_next, branch_next, repeat_next, adv_next, pchk_next, cchk_next, inv_next;
    logic [ADDR_W-1:0] iar_next, arr_next, image_next, data_next;
    logic [7:0] left_next, right_next;
    logic parity_err, load_busy;

    assign parity_err = ours && (kind != lp_attach_pkg::KIND_NONE) && !parity_ok;

    always_comb begin
        done_next = ours && (kind != lp_attach_pkg::KIND_NONE);
        branch_next = 1'b0;
        repeat_next = 1'b0;
        adv_next = 1'b0;
        pchk_next = 1'b0;
        cchk_next = 1'b0;
        inv_next = 1'b0;
        iar_next = o_iar;
        arr_next = o_arr;
        left_next = o_forms_left;
        right_next = o_forms_right;
        image_next = o_image_addr;
        data_next = o_data_addr;
        load_busy = (n_code == `LPA_LOAD_FORMS) ? (|o_carr_busy) : o_buf_busy;
        if (parity_err) begin
            pchk_next = check_is_program;
            cchk_next = ~check_is_program;
        end else if (done_next) begin
            unique case (kind)
                lp_attach_pkg::KIND_TEST: begin
                    if (sel_invalid) begin
                        cchk_next = 1'b1;
                        inv_next = pins[`LPA_PIN_VARIANT_DUAL];
                    end else begin
                        // The condition register is not touched by a test.
                        branch_next = sel_hit;
                        iar_next = sel_hit ? i_operand_addr : i_next_addr;
                        arr_next = sel_hit ? i_next_addr : i_operand_addr;
                    end
                end
                lp_attach_pkg::KIND_ADVANCE: begin
                    if (sel_invalid) begin
                        cchk_next = 1'b1;
                        inv_next = pins[`LPA_PIN_VARIANT_DUAL];
                    end else if (sel_hit) begin
                        adv_next = i_dual_installed & i_dual_enabled;
                        repeat_next = ~(i_dual_installed & i_dual_enabled);
                    end
                end
                lp_attach_pkg::KIND_LOAD: begin
                    if (o_refused) begin
                        repeat_next = 1'b0;
                    end else if (n_code != `LPA_LOAD_FORMS && n_code != `LPA_LOAD_IMAGE
                                 && n_code != `LPA_LOAD_DATA) begin
                        pchk_next = check_is_program;
                        cchk_next = ~check_is_program;
                    end else if (load_busy) begin
                        repeat_next = 1'b1;
                    end else if (n_code == `LPA_LOAD_FORMS) begin
                        right_next = i_data_ea;
                        left_next = i_data_ea_m1;
                    end else if (n_code == `LPA_LOAD_IMAGE) begin
                        image_next = {i_data_ea_m1, i_data_ea};
                    end else begin
                        data_next = {i_data_ea_m1, i_data_ea};
                    end
                end
                default: begin
                    branch_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_done <= 1'b0;
            o_branch <= 1'b0;
            o_repeat <= 1'b0;
            o_level_advance <= 1'b0;
            o_program_check <= 1'b0;
            o_processor_check <= 1'b0;
            o_invalid_dev_addr <= 1'b0;
            o_iar <= '0;
            o_arr <= '0;
            o_forms_left <= 8'h00;
            o_forms_right <= 8'h00;
            o_image_addr <= '0;
            o_data_addr <= '0;
        end else begin
            o_done <= done_next;
            o_branch <= branch_next;
            o_repeat <= repeat_next;
            o_level_advance <= adv_next;
            o_program_check <= pchk_next;
            o_processor_check <= cchk_next;
            o_invalid_dev_addr <= inv_next;
            o_iar <= iar_next;
            o_arr <= arr_next;
            o_forms_left <= left_next;
            o_forms_right <= right_next;
            o_image_addr <= image_next;
            o_data_addr <= data_next;
        end
    end

    a_foreign_silent: assert property (i_instr_valid && i_qbyte[7:4] != `LPA_DEV_ADDR |=> !o_done)
        else $error("Answered an instruction for another device.");
    a_branch_addrs: assert property (o_done && o_branch |-> o_iar == $past(i_operand_addr)
        && o_arr == $past(i_next_addr))
        else $error("Taken branch addresses wrong.");
    a_load_skipped: assert property (ours && parity_ok && kind == lp_attach_pkg::KIND_LOAD && o_refused
        |=> o_done && !o_repeat && $stable(o_forms_left) && $stable(o_image_addr))
        else $error("Load acted while refused bit set.");

    sequence s_bad_load;
        ours && parity_ok && kind == lp_attach_pkg::KIND_LOAD && !o_refused && n_code == 3'h2;
    endsequence
    a_bad_load_check: assert property (s_bad_load ##0 !check_is_program |=> o_processor_check
        && !o_program_check)
        else $error("Invalid load code did not give a processor check.");

    // ========================================
    // Refused bit, parity indicator and op-end request
    logic refused_next, parity_next, irq_en_next, pending_next, acc_next, events, post, immediate;
    logic sense_ours;
    logic irq_en_reg, acc_reg;
    assign sense_ours = ours && parity_ok && kind == lp_attach_pkg::KIND_SENSE;
    assign events = (o_buf_busy & ~buf_next) | (|(o_carr_busy & ~carr_next)) | (i_start_accept & i_start_refused);

    always_comb begin
        refused_next = (i_start_accept & i_start_refused) | (o_refused & ~(sense_ours | i_check_reset));
        parity_next = parity_err | (o_parity_light & ~i_check_reset);
        irq_en_next = irq_en_reg;
        if (i_start_accept && (i_start_int_enable || i_start_reset_enable)) begin
            irq_en_next = 1'b1;
        end else if (i_start_accept && i_start_int_disable) begin
            irq_en_next = 1'b0;
        end
        // Idle on enable posts at once, except through reset-and-enable.
        immediate = i_start_accept && i_start_int_enable && !i_start_reset_enable && !irq_en_reg
                    && !buf_next && !(|carr_next);
        // Events wait until an instruction ends with interrupts enabled.
        post = done_next && irq_en_reg && (acc_reg || events);
        acc_next = post ? 1'b0 : (acc_reg | events);
        pending_next = post | immediate | (o_irq_req & ~(i_start_accept & i_start_reset_enable));
    end


    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_refused <= 1'b0;
            o_parity_light <= 1'b0;
            irq_en_reg <= 1'b0;
            acc_reg <= 1'b0;
            o_irq_req <= 1'b0;
        end else begin
            o_refused <= refused_next;
            o_parity_light <= parity_next;
            irq_en_reg <= irq_en_next;
            acc_reg <= acc_next;
            o_irq_req <= pending_next;
        end
    end

    a_irq_post_end: assert property (done_next && irq_en_reg && events |=> o_irq_req)
        else $error("Op-end request not posted at instruction end.");
    a_irq_hold: assert property (o_irq_req && !(i_start_accept && i_start_reset_enable) |=> o_irq_req)
        else $error("Pending request lost without reset-and-enable.");
    a_reset_enable_quiet: assert property (i_start_accept && i_start_reset_enable && !post |=> !o_irq_req)
        else $error("Reset-and-enable left a request pending.");
    a_refused_clear: assert property (sense_ours && !(i_start_accept && i_start_refused) |=> !o_refused)
        else $error("Sense did not clear the refused bit.");
    a_parity_light: assert property (parity_err |=> o_parity_light && (o_program_check || o_processor_check))
        else $error("Parity error not reported.");

endmodule

/* sim/lp_core_model.sv */
// Processor core model: issues one instruction and collects the answer pulses.
// Assumes the attachment answers within three cycles or not at all.
module lp_core_model (
    // Clock and answer pulses.
    input wire logic clk,
    input wire logic [6:0] ans,
    // Instruction fields.
    output logic valid = 0,
    output logic [7:0] op = 0,
    output logic [7:0] q = 0,
    output logic par = 0,
    output logic [15:0] opa = 0,
    output logic [15:0] nxt = 0,
    output logic [7:0] ea = 0,
    output logic [7:0] eam1 = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Drives one instruction for one cycle, then spoils the fields and waits for o_done.
    task automatic issue(input logic [7:0] o, qq, input logic bad, input logic [15:0] a, n,
                         input logic [7:0] d1, d0, output logic [6:0] r);
        r = 0;
        @(negedge clk);
        {valid, op, q, opa, nxt, eam1, ea} = {1'b1, o, qq, a, n, d1, d0};
        par = ~(^qq) ^ bad;
        @(negedge clk);
        {valid, op, q, opa, nxt, eam1, ea} = ~{1'b1, o, qq, a, n, d1, d0};
        for (int i = 0; i < 3 && r == 0; i++) begin
            if (ans[5] === 1'b1) r = ans;
            @(negedge clk);
        end
    endtask
endmodule

/* sim/line_printer_io_attachment_bench.sv */
// Self-checking bench for the line printer attachment.
// Assumes the core model above and the design files under logic/.
module line_printer_io_attachment_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 0, i_reset_n = 0, acc = 0, pr = 0, mo = 0, rf = 0, en = 0, re = 0;
    logic ld = 0, md = 0, ck = 0, dual = 0, lv7 = 1, valid, par, done, br, rep, adv, pc, xc;
    logic irq, refd, pl, bb, pb, inv, nr = 0, vd = 0;
    logic [1:0] cb;
    logic [7:0] op, q, ea, eam1, fl, fr;
    logic [15:0] opa, nxt, instruction_address_reg, return_address_reg, img, dat, a, n, old;
    logic [7:0] d1, d0;
    logic [6:0] r;
    int seed = 16, num_errors = 0, num_checks = 0;
    // Clock of 4 ns.
    always #2 i_ref_clk = ~i_ref_clk;
    // ========================================
    // Core model and design.
    lp_core_model core (.clk(i_ref_clk), .ans({inv, done, br, rep, adv, pc, xc}), .valid(valid), .op(op), .q(q),
        .par(par), .opa(opa), .nxt(nxt), .ea(ea), .eam1(eam1));
    lp_attach dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_instr_valid(valid), .i_opcode(op),
        .i_qbyte(q), .i_qbyte_parity(par), .i_operand_addr(opa), .i_next_addr(nxt), .i_data_ea(ea),
        .i_data_ea_m1(eam1), .i_level7_enabled(lv7), .i_interrupt_model(1'b1), .i_dual_installed(dual),
        .i_dual_enabled(dual), .i_check_reset(ck), .i_start_accept(acc), .i_start_print(pr),
        .i_start_motion(mo), .i_start_right(1'b0), .i_start_refused(rf), .i_start_int_enable(en),
        .i_start_int_disable(1'b0), .i_start_reset_enable(re), .i_mech_not_ready(nr), .i_mech_line_done(ld),
        .i_mech_motion_done_l(md), .i_mech_motion_done_r(md), .i_mech_diag_off(1'b0),
        .i_strap_dual_carriage(1'b0), .i_strap_variant_dual(vd), .o_done(done), .o_branch(br),
        .o_repeat(rep), .o_level_advance(adv), .o_program_check(pc), .o_processor_check(xc),
        .o_invalid_dev_addr(inv), .o_iar(instruction_address_reg), .o_arr(return_address_reg), .o_irq_req(irq), .o_refused(refd),
        .o_parity_light(pl), .o_buf_busy(bb), .o_carr_busy(cb), .o_printer_busy(pb), .o_forms_left(fl),
        .o_forms_right(fr), .o_image_addr(img), .o_data_addr(dat));
    // ========================================
    // Shared tasks.
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Expected branch flag, instruction address and return address after a test.
    function automatic logic [32:0] exp_branch(input logic hit, input logic [15:0] t, nx);
        return {hit, hit ? t : nx, hit ? nx : t};
    endfunction
    task automatic chk(input logic [63:0] s, e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic st(input logic p, m, f, e, x);
        @(negedge i_ref_clk);
        {acc, pr, mo, rf, en, re} = {1'b1, p, m, f, e, x};
        @(negedge i_ref_clk);
        {acc, pr, mo, rf, en, re} = 0;
        repeat (2) @(negedge i_ref_clk);
    endtask
    task automatic go(input logic [7:0] o, qq, input logic bad);
        {a, n, d1, d0} = 48'({$random(seed), $random(seed)});
        core.issue(o, qq, bad, a, n, d1, d0, r);
    endtask
    // Waits a bounded time for a busy flag to drop; running out is a mismatch.
    task automatic idle(input int which);
        for (int i = 0; i < 12 && (which ? cb[0] : bb) !== 1'b0; i++) @(negedge i_ref_clk);
        if ((which ? cb[0] : bb) !== 1'b0) begin
            num_errors++;
            end_sim();
        end
    endtask
    // ========================================
    // Main sequence.
    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_reset_n = 1;
        repeat (3) @(negedge i_ref_clk);
        chk({irq, refd, pl, bb, pb}, 0);
        for (int i = 0; i < 3; i++) begin
            go(i == 0 ? 8'h31 : i == 1 ? 8'h71 : 8'hb1, i == 0 ? 8'he0 : i == 1 ? 8'he4 : 8'he6, 0);
            chk(r, 7'h20);
            chk(i == 0 ? {fl, fr} : i == 1 ? img : dat, {d1, d0});
        end
        go(8'h31, 8'he1, 0);
        chk(r[1:0], 2'b10);
        lv7 = 0;
        go(8'hb1, 8'he3, 0);
        chk(r[1:0], 2'b01);
        go(8'hc1, 8'hd2, 0);
        chk(r, 0);
        go(8'hc1, 8'he2, 1);
        chk({r[5], r[1:0], pl}, 4'b1011);
        $display("test loads and checks done");
        st(1, 1, 0, 0, 0);
        chk({bb, cb, pb}, 4'b1011);
        go(8'hd1, 8'he2, 0);
        chk({r[4], instruction_address_reg, return_address_reg}, exp_branch(1, a, n));
        go(8'h31, 8'he6, 0);
        chk(r[3], 1);
        ld = 1;
        idle(0);
        chk({cb[0], pb}, 2'b11);
        go(8'he1, 8'he2, 0);
        chk({r[4], instruction_address_reg, return_address_reg}, exp_branch(0, a, n));
        go(8'hc1, 8'he4, 0);
        chk({r[4], instruction_address_reg, return_address_reg}, exp_branch(1, a, n));
        md = 1;
        idle(1);
        chk({cb, pb}, 0);
        {ld, md} = 0;
        $display("test busy done");
        st(0, 0, 0, 1, 0);
        chk(irq, 1);
        go(8'hc1, 8'he3, 0);
        chk({r[4], irq}, 2'b11);
        go(8'hf1, 8'he3, 0);
        chk(r[3:2], 2'b10);
        dual = 1;
        go(8'hf1, 8'he3, 0);
        chk(r[3:2], 2'b01);
        st(0, 0, 0, 0, 1);
        chk(irq, 0);
        go(8'hc1, 8'he3, 0);
        chk(r[4], 0);
        $display("test interrupt done");
        st(0, 0, 1, 0, 0);
        chk(refd, 1);
        old = {fl, fr};
        go(8'h31, 8'he0, 0);
        chk({r, fl, fr}, {7'h20, old});
        chk(irq, 1);
        go(8'h30, 8'he3, 0);
        chk(refd, 0);
        $display("test refused done");
        nr = 1;
        repeat (3) @(negedge i_ref_clk);
        go(8'hc1, 8'he1, 0);
        chk({r[4], instruction_address_reg, return_address_reg}, exp_branch(1, a, n));
        {nr, vd} = 2'b01;
        repeat (3) @(negedge i_ref_clk);
        go(8'hc1, 8'he1, 0);
        chk({r[4], instruction_address_reg, return_address_reg}, exp_branch(0, a, n));
        go(8'hc1, 8'he9, 0);
        chk(r, 7'h61);
        vd = 0;
        repeat (3) @(negedge i_ref_clk);
        go(8'hc1, 8'he9, 0);
        chk(r, 7'h20);
        go(8'hc1, 8'hea, 0);
        chk(r, 7'h21);
        $display("test conditions done");
        end_sim();
    end
endmodule
